/* shared/sffc_pkg.sv */
// Constants and types for the serial frame format control register bank
package sffc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SFFC_FMT_CTRL_ADDR = 8'h02;
    localparam logic [7:0] SFFC_DATA_ADDR = 8'h04;
    localparam logic [15:0] SFFC_FMT_CTRL_RST = 16'h0000;
    localparam logic [15:0] SFFC_FMT_CTRL_MASK = 16'h004D;
    localparam logic [23:0] SFFC_DATA_RST = 24'h000000;
    localparam logic [7:0] SFFC_STAT_RST = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SFFC_SHORT_WORD_POS = 0;
    localparam int SFFC_CHK_LO_POS = 2;
    localparam int SFFC_CHK_HI_POS = 3;
    localparam int SFFC_APPEND_POS = 6;

    // Checksum field codes
    localparam logic [1:0] SFFC_CHK_OFF = 2'h0;
    localparam logic [1:0] SFFC_CHK_XOR_CRC = 2'h1;
    localparam logic [1:0] SFFC_CHK_CRC_CRC = 2'h2;
    localparam logic [1:0] SFFC_CHK_RSVD = 2'h3;

    // Frame byte counts
    localparam logic [2:0] SFFC_CTRL_BYTES = 3'h2;
    localparam logic [2:0] SFFC_LONG_BYTES = 3'h3;
    localparam logic [2:0] SFFC_SHORT_BYTES = 3'h2;

    // Kind of protection byte on one direction of the serial port
    typedef enum logic [1:0] {SFFC_PROT_NONE, SFFC_PROT_XOR, SFFC_PROT_CRC} sffc_prot_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } sffc_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic [2:0] nbytes;
    } sffc_rsp_t;

    typedef struct packed {
        logic valid;
        logic [23:0] result;
        logic [7:0] status;
    } sffc_conv_t;

    typedef struct packed {
        sffc_prot_t rd_prot;
        sffc_prot_t wr_prot;
        logic extra_byte;
    } sffc_chk_t;
endpackage

/* hdl/sffc_regs.sv */
// Serial frame format control register and the conversion data register it governs
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ns
module sffc_regs
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input sffc_pkg::sffc_req_t req_i,
    output sffc_pkg::sffc_rsp_t rsp_o,
    input wire logic [1:0] fe_chk_en_i,
    input sffc_pkg::sffc_conv_t conv_i,
    output sffc_pkg::sffc_chk_t chk_o,
    output logic status_append_o,
    output logic short_word_select_o
);
    import sffc_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] fmt_ctrl_ff;
    logic [23:0] data_ff;
    logic [7:0] stat_ff;
    logic data_short_ff;
    sffc_rsp_t rsp_ff;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic hit_ctrl = req_i.addr == SFFC_FMT_CTRL_ADDR;
    wire logic hit_data = req_i.addr == SFFC_DATA_ADDR;
    wire logic wr_ctrl = req_i.wr && hit_ctrl;
    wire logic [1:0] chk_field = fmt_ctrl_ff[SFFC_CHK_HI_POS:SFFC_CHK_LO_POS];
    wire logic short_sel = fmt_ctrl_ff[SFFC_SHORT_WORD_POS];
    wire logic append_sel = fmt_ctrl_ff[SFFC_APPEND_POS];
    wire logic fe_on = fe_chk_en_i != 2'h0;
    wire logic chk_on = fe_on && (chk_field == SFFC_CHK_XOR_CRC || chk_field == SFFC_CHK_CRC_CRC);
    wire sffc_prot_t rd_prot = !chk_on ? SFFC_PROT_NONE
        : (chk_field == SFFC_CHK_XOR_CRC) ? SFFC_PROT_XOR : SFFC_PROT_CRC;
    wire sffc_prot_t wr_prot = chk_on ? SFFC_PROT_CRC : SFFC_PROT_NONE;
    wire logic [2:0] chk_bytes = {2'h0, chk_on};

    // ------------------------------------------------------------
    // Rounding to 16 bits, saturating at full scale
    // ------------------------------------------------------------
    wire logic top_full = conv_i.result[23:8] == 16'hFFFF;
    wire logic [15:0] rounded = top_full ? 16'hFFFF
        : conv_i.result[23:8] + {15'h0000, conv_i.result[7]};
    wire logic [23:0] new_data = short_sel ? {8'h00, rounded} : conv_i.result;

    // ------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------
    wire logic [2:0] word_bytes = data_short_ff ? SFFC_SHORT_BYTES : SFFC_LONG_BYTES;
    wire logic [31:0] data_word = append_sel
        ? (data_short_ff ? {8'h00, data_ff[15:0], stat_ff} : {data_ff, stat_ff})
        : {8'h00, data_ff};
    wire logic [2:0] data_bytes = word_bytes + {2'h0, append_sel} + chk_bytes;
    wire logic [31:0] rd_word = hit_ctrl ? {16'h0000, fmt_ctrl_ff}
        : hit_data ? data_word : 32'h00000000;
    wire logic [2:0] rd_bytes = hit_ctrl ? SFFC_CTRL_BYTES + chk_bytes
        : hit_data ? data_bytes : 3'h0;

    // ------------------------------------------------------------
    // Format register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            fmt_ctrl_ff <= SFFC_FMT_CTRL_RST;
        else if (wr_ctrl)
            fmt_ctrl_ff <= req_i.wdata & SFFC_FMT_CTRL_MASK;
    end

    // ------------------------------------------------------------
    // Data register, width fixed at capture
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            data_ff <= SFFC_DATA_RST;
            stat_ff <= SFFC_STAT_RST;
            data_short_ff <= 1'b0;
        end
        else if (conv_i.valid)
        begin
            data_ff <= new_data;
            stat_ff <= conv_i.status;
            data_short_ff <= short_sel;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rsp_ff <= '0;
        else
        begin
            rsp_ff.valid <= req_i.rd;
            rsp_ff.data <= req_i.rd ? rd_word : 32'h00000000;
            rsp_ff.nbytes <= req_i.rd ? rd_bytes : 3'h0;
        end
    end

    assign rsp_o = rsp_ff;
    assign chk_o = '{rd_prot: rd_prot, wr_prot: wr_prot, extra_byte: chk_on};
    assign status_append_o = append_sel;
    assign short_word_select_o = short_sel;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    property p_chk_needs_both;
        chk_o.extra_byte |-> (fe_chk_en_i != 2'h0 && chk_field != SFFC_CHK_OFF && chk_field != SFFC_CHK_RSVD);
    endproperty
    a_chk_needs_both: assert property (p_chk_needs_both) else $error("checksum active without both enables");

    property p_xor_mode;
        (fe_chk_en_i != 2'h0 && chk_field == SFFC_CHK_XOR_CRC)
            |-> (chk_o.extra_byte && chk_o.rd_prot == SFFC_PROT_XOR && chk_o.wr_prot == SFFC_PROT_CRC);
    endproperty
    a_xor_mode: assert property (p_xor_mode) else $error("code 01 protection kinds wrong");

    property p_crc_mode;
        (fe_chk_en_i != 2'h0 && chk_field == SFFC_CHK_CRC_CRC)
            |-> (chk_o.extra_byte && chk_o.rd_prot == SFFC_PROT_CRC && chk_o.wr_prot == SFFC_PROT_CRC);
    endproperty
    a_crc_mode: assert property (p_crc_mode) else $error("code 10 protection kinds wrong");

    property p_ctrl_bytes;
        (req_i.rd && hit_ctrl)
            |=> rsp_o.valid && rsp_o.nbytes == ($past(chk_o.extra_byte) ? 3'h3 : 3'h2);
    endproperty
    a_ctrl_bytes: assert property (p_ctrl_bytes) else $error("format register frame length wrong");

    sequence s_capture;
        conv_i.valid ##1 !conv_i.valid;
    endsequence
    sequence s_read_data;
        req_i.rd && hit_data && status_append_o && !conv_i.valid;
    endsequence
    property p_append_status;
        s_capture ##1 s_read_data |=> rsp_o.data[7:0] == $past(conv_i.status, 3);
    endproperty
    a_append_status: assert property (p_append_status) else $error("appended status not of this result");

    property p_long_word;
        (conv_i.valid && !short_word_select_o) |=> data_ff == $past(conv_i.result);
    endproperty
    a_long_word: assert property (p_long_word) else $error("24-bit result not kept whole");

    property p_short_round;
        (conv_i.valid && short_word_select_o && conv_i.result[23:8] != 16'hFFFF)
            |=> data_ff == {8'h00, $past(conv_i.result[23:8]) + {15'h0000, $past(conv_i.result[7])}};
    endproperty
    a_short_round: assert property (p_short_round) else $error("16-bit result not rounded");

    property p_width_held;
        (wr_ctrl && !conv_i.valid) |=> $stable(data_ff) && $stable(data_short_ff);
    endproperty
    a_width_held: assert property (p_width_held) else $error("format write disturbed held result");

    property p_reserved_zero;
        wr_ctrl |=> (fmt_ctrl_ff & ~SFFC_FMT_CTRL_MASK) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_data_read_only;
        (req_i.wr && hit_data && !conv_i.valid) |=> $stable(data_ff);
    endproperty
    a_data_read_only: assert property (p_data_read_only) else $error("data register was written");

    // ------------------------------------------------------------
    // Disabled protection, frame lengths and capture width
    // ------------------------------------------------------------
    property p_chk_off;
        (fe_chk_en_i == 2'h0 || chk_field == SFFC_CHK_OFF || chk_field == SFFC_CHK_RSVD)
            |-> (!chk_o.extra_byte && chk_o.rd_prot == SFFC_PROT_NONE && chk_o.wr_prot == SFFC_PROT_NONE);
    endproperty
    a_chk_off: assert property (p_chk_off) else $error("checksum byte present while disabled");

    property p_data_bytes;
        (req_i.rd && hit_data) |=> rsp_o.valid
            && rsp_o.nbytes == (($past(data_short_ff) ? SFFC_SHORT_BYTES : SFFC_LONG_BYTES)
                + {2'h0, $past(status_append_o)} + {2'h0, $past(chk_o.extra_byte)});
    endproperty
    a_data_bytes: assert property (p_data_bytes) else $error("data register frame length wrong");

    property p_short_saturate;
        (conv_i.valid && short_word_select_o && conv_i.result[23:8] == 16'hFFFF) |=> data_ff == 24'h00FFFF;
    endproperty
    a_short_saturate: assert property (p_short_saturate) else $error("full scale 16-bit result wrapped");

    property p_width_from_capture;
        conv_i.valid |=> data_short_ff == $past(short_word_select_o);
    endproperty
    a_width_from_capture: assert property (p_width_from_capture) else $error("held width not from capture");

    property p_unmapped_read;
        (req_i.rd && !hit_ctrl && !hit_data)
            |=> rsp_o.valid && rsp_o.data == 32'h00000000 && rsp_o.nbytes == 3'h0;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read returned data");

    property p_reserved_always;
        (fmt_ctrl_ff & ~SFFC_FMT_CTRL_MASK) == 16'h0000;
    endproperty
    a_reserved_always: assert property (p_reserved_always) else $error("reserved bits held a one");
endmodule

/* verification/sffc_host.sv */
// Host controller model driving the register port of the format control bank
`timescale 1ns/1ns
module sffc_host
(
    input wire logic core_clk_i,
    input sffc_pkg::sffc_rsp_t rsp_i,
    output sffc_pkg::sffc_req_t req_o
);
    import sffc_pkg::*;
    initial req_o = '0;
    // ------------------------------------------------------------
    // One register cycle: strobe for one edge, answer one edge later
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output sffc_rsp_t r);
        @(posedge core_clk_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge core_clk_i);
        // Released lines show a changed value, not the old one
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        // Answer launched one edge back still stands here
        @(posedge core_clk_i);
        r = rsp_i;
    endtask
endmodule

/* verification/tb.sv */
// Self-checking testbench for the serial frame format control registers
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
    import sffc_pkg::*;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [1:0] fe_chk_en = 2'h0;
    sffc_conv_t conv = '0;
    sffc_req_t req;
    sffc_rsp_t rsp, r;
    sffc_chk_t chk;
    logic append, short_w, x, w;
    logic [23:0] res;
    logic [7:0] st;
    logic [15:0] cfg;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 93498;
    always #5 core_clk_i = ~core_clk_i;
    sffc_regs u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(req), .rsp_o(rsp), .fe_chk_en_i(fe_chk_en),
        .conv_i(conv), .chk_o(chk), .status_append_o(append), .short_word_select_o(short_w));
    sffc_host u_host (.core_clk_i(core_clk_i), .rsp_i(rsp), .req_o(req));
    // ------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------
    function automatic logic chk_on(input logic [1:0] code, input logic [1:0] fe);
        return (code == SFFC_CHK_XOR_CRC || code == SFFC_CHK_CRC_CRC) && fe != 2'h0;
    endfunction
    function automatic logic [34:0] exp_data(input logic [23:0] v, input logic [7:0] s, input logic sw,
        input logic ap, input logic ex);
        logic [15:0] r16;
        r16 = (v[23:8] == 16'hFFFF) ? 16'hFFFF : v[23:8] + 16'(v[7]);
        if (sw)
            return {3'(2 + ap + ex), ap ? {8'h00, r16, s} : {16'h0000, r16}};
        return {3'(3 + ap + ex), ap ? {v, s} : {8'h00, v}};
    endfunction
    // ------------------------------------------------------------
    // Shared stimulus tasks
    // ------------------------------------------------------------
    task automatic set_cfg(input logic [15:0] v);
        u_host.xfer(1'b1, SFFC_FMT_CTRL_ADDR, v, r);
        cfg = v & 16'h004D;
    endtask
    task automatic convert(input logic [23:0] v, input logic [7:0] s);
        @(posedge core_clk_i);
        conv <= '{valid: 1'b1, result: v, status: s};
        @(posedge core_clk_i);
        conv <= '{valid: 1'b0, result: ~v, status: ~s};
    endtask
    task automatic check_data(input logic [23:0] v, input logic [7:0] s, input logic sw);
        u_host.xfer(1'b0, SFFC_DATA_ADDR, 16'h0000, r);
        `CHK(r.valid, 1'b1)
        `CHK(({r.nbytes, r.data}), exp_data(v, s, sw, cfg[6], chk_on(cfg[3:2], fe_chk_en)))
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        cfg = 16'h0000;
        repeat (10) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        u_host.xfer(1'b0, SFFC_FMT_CTRL_ADDR, 16'h0000, r);
        `CHK(({r.valid, r.nbytes, r.data}), ({1'b1, 3'h2, 32'h0}))
        `CHK(({append, short_w, chk}), 7'h00)
        check_data(24'h0, 8'h0, 1'b0);
        $display("test reset done");
        set_cfg(16'hFFFF);
        u_host.xfer(1'b0, SFFC_FMT_CTRL_ADDR, 16'h0000, r);
        `CHK(r.data, 32'h0000004D)
        `CHK(({append, short_w}), 2'h3)
        u_host.xfer(1'b1, SFFC_DATA_ADDR, 16'h1234, r);
        check_data(24'h0, 8'h0, 1'b0);
        u_host.xfer(1'b0, 8'h07, 16'h0000, r);
        `CHK(({r.nbytes, r.data}), ({3'h0, 32'h0}))
        $display("test reserved and unmapped done");
        for (int c = 0; c < 4; c++)
            for (int f = 0; f < 4; f++)
            begin
                fe_chk_en <= 2'(f);
                set_cfg(16'(c << 2));
                x = chk_on(2'(c), 2'(f));
                `CHK(chk.extra_byte, x)
                `CHK(chk.rd_prot, !x ? SFFC_PROT_NONE : (c == 1) ? SFFC_PROT_XOR : SFFC_PROT_CRC)
                `CHK(chk.wr_prot, x ? SFFC_PROT_CRC : SFFC_PROT_NONE)
                u_host.xfer(1'b0, SFFC_FMT_CTRL_ADDR, 16'h0000, r);
                `CHK(r.nbytes, 3'(2 + x))
            end
        $display("test checksum modes done");
        for (int i = 0; i < 40; i++)
        begin
            res = (i == 0) ? 24'hFFFFFF : (i == 1) ? 24'h12347F : (i == 2) ? 24'h123480 : 24'($random(seed));
            st = 8'($random(seed));
            fe_chk_en <= 2'($random(seed));
            set_cfg(16'($random(seed)) | ((i < 3) ? 16'h0001 : 16'h0000));
            convert(res, st);
            w = cfg[0];
            if (i % 4 == 0)
                set_cfg(cfg ^ 16'h0041);
            check_data(res, st, w);
        end
        $display("test conversions done");
        report_and_stop();
    end
    initial
    begin
        #100000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule
